// *** clkctl_pkg.sv ***
// package: register map, field positions, reset values and timing for the clock control block
package clkctl_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] pll_clock_control_addr = 12'h000;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;
    // ****************************************
    // field positions
    // ****************************************
    localparam int osc_halt_bit = 7;
    localparam int lock_bit = 6;
    localparam int reserved_bit = 5;
    localparam int ext_access_bit = 4;
    localparam int fast_irq_bit = 3;
    localparam int div_lsb = 0;
    localparam int div_width = 3;
    localparam logic [2:0] div_default = 3'h3;
    localparam logic [2:0] div_fastest = 3'h0;
    localparam logic [2:0] div_slowest = 3'h7;
    localparam logic [7:0] ctrl_reset = 8'h03;
    localparam int pll_multiplier = 384;
endpackage : clkctl_pkg

// *** clkdiv_if.sv ***
// interface: divider setting between control logic and the core clock enable divider
interface clkdiv_if;
    logic [2:0] div_sel;
    logic core_clk_en;
    modport ctrl (output div_sel, input core_clk_en);
    modport div (input div_sel, output core_clk_en);
endinterface : clkdiv_if

// *** core_clk_divider.sv ***
// module: binary divider producing the core clock enable pulse from the pll clock
module core_clk_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divider link
    clkdiv_if.div link
);
    import clkctl_pkg::*;

    logic [6:0] count;
    logic [6:0] mask;

    // a code of n makes a pulse every 2^n pll clocks
    assign mask = 7'((8'h01 << link.div_sel) - 8'h01);
    assign link.core_clk_en = ((count & mask) == 7'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01; // [RQ11]
        end
    end
endmodule : core_clk_divider

// *** pll_clock_ctrl.sv ***
// module: pll and core clock control register with apb slave
// Operation
// RQ1 - halt bit set stops oscillator in power-down
// RQ2 - halt bit clear keeps oscillator running
// RQ3 - lock bit is read-only
// RQ4 - lock bit sets when pll tracks crystal
// RQ5 - lock bit clears when pll not tracking
// RQ6 - software polls lock after wake-up
// RQ7 - bit 4 returns ext access pin at reset
// RQ8 - fast bit runs interrupts at fastest clock
// RQ9 - after interrupt return, divider clock resumes
// RQ10 - fast bit clear, interrupts use divider clock
// RQ11 - three-bit divider, 000 fastest, default 011
// RQ12 - pll locks at 384 times crystal
// RQ13 - bit 5 reserved, reads zero
//
// The APB slave port and the register offsets are this design's own decisions.
module pll_clock_ctrl (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and pll status
    input wire logic ext_access_pin,
    input wire logic pll_tracking,
    // core side
    input wire logic powerdown,
    input wire logic irq_active,
    output logic osc_enable,
    output logic core_clk_en,
    output logic [2:0] core_clk_div_eff
);
    import clkctl_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic pin_s1;
    logic pin_s2;
    logic lock_s1;
    logic lock_s2;

    // both inputs are asynchronous, so nothing but the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            pin_s1 <= ext_access_pin;
            pin_s2 <= pin_s1;
            lock_s1 <= pll_tracking; // [RQ4] [RQ5]
            lock_s2 <= lock_s1;
        end
    end

    // ****************************************
    // pin capture after reset
    // ****************************************
    // the pin is caught once, after the synchroniser has refilled; later pin
    // changes are ignored until the next reset
    typedef enum logic [3:0] {
        cap_fill0 = 4'b0001,
        cap_fill1 = 4'b0010,
        cap_take = 4'b0100,
        cap_done = 4'b1000
    } capture_state_t;

    capture_state_t capture_state;
    capture_state_t next_capture_state;
    logic latched_ext_access_pin;
    logic next_latched_ext_access_pin;

    always_comb begin
        next_capture_state = capture_state;
        next_latched_ext_access_pin = latched_ext_access_pin;
        case (capture_state)
            cap_fill0: begin
                next_capture_state = cap_fill1;
            end
            cap_fill1: begin
                next_capture_state = cap_take;
            end
            cap_take: begin
                next_latched_ext_access_pin = pin_s2; // [RQ7]
                next_capture_state = cap_done;
            end
            cap_done: begin
                next_capture_state = cap_done;
            end
            default: begin
                next_capture_state = cap_fill0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_state <= cap_fill0;
            latched_ext_access_pin <= 1'b0;
        end else begin
            capture_state <= next_capture_state;
            latched_ext_access_pin <= next_latched_ext_access_pin;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    logic osc_halt_in_powerdown;
    logic fast_irq_clock;
    logic [2:0] core_clk_div;
    logic hit;
    logic access_phase;
    logic wr_en;
    logic rd_setup;
    logic next_osc_halt_in_powerdown;
    logic next_fast_irq_clock;
    logic [2:0] next_core_clk_div;

    assign hit = (paddr == pll_clock_control_addr);
    assign access_phase = psel && penable;
    // lane 0 carries the whole register, so a write without it changes nothing
    assign wr_en = access_phase && pwrite && hit && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;

    // lock, reserved and pin bits take no write data [RQ3] [RQ13]
    assign next_osc_halt_in_powerdown = wr_en ? pwdata[osc_halt_bit] : osc_halt_in_powerdown;
    assign next_fast_irq_clock = wr_en ? pwdata[fast_irq_bit] : fast_irq_clock;
    assign next_core_clk_div = wr_en ? pwdata[div_lsb +: div_width] : core_clk_div; // [RQ11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_halt_in_powerdown <= ctrl_reset[osc_halt_bit];
            fast_irq_clock <= ctrl_reset[fast_irq_bit];
            core_clk_div <= div_default; // [RQ11]
        end else begin
            osc_halt_in_powerdown <= next_osc_halt_in_powerdown;
            fast_irq_clock <= next_fast_irq_clock;
            core_clk_div <= next_core_clk_div;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // unused and reserved positions read zero
    function automatic logic [7:0] pack_view(
        input logic halt,
        input logic locked,
        input logic pin,
        input logic fast,
        input logic [2:0] div
    );
        logic [7:0] view;
        view = 8'h00; // [RQ13]
        view[osc_halt_bit] = halt;
        view[lock_bit] = locked; // [RQ4] [RQ5]
        view[ext_access_bit] = pin; // [RQ7]
        view[fast_irq_bit] = fast;
        view[div_lsb +: div_width] = div;
        return view;
    endfunction : pack_view

    logic [7:0] reg_view;
    logic [31:0] next_prdata;
    assign reg_view = pack_view(osc_halt_in_powerdown, lock_s2, latched_ext_access_pin,
        fast_irq_clock, core_clk_div);
    assign next_prdata = hit ? {24'h00_0000, reg_view} : unmapped_read;

    // zero wait states; unmapped addresses read zero and report an error
    assign pready = 1'b1;
    assign pslverr = access_phase && !hit;

    // read data is taken at the setup edge, so it already stands in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // clocking
    // ****************************************
    // the pll (x384 of the crystal) is modelled as pclk itself [RQ12]
    assign osc_enable = !(powerdown && osc_halt_in_powerdown); // [RQ1] [RQ2]

    logic fast_active;
    logic [2:0] next_div;
    // fast mode only while an interrupt is serviced; the plain setting returns after it
    assign fast_active = fast_irq_clock && irq_active; // [RQ8] [RQ10]
    assign next_div = fast_active ? div_fastest : core_clk_div; // [RQ8] [RQ9]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clk_div_eff <= div_default;
        end else begin
            core_clk_div_eff <= next_div;
        end
    end

    clkdiv_if link ();
    assign link.div_sel = core_clk_div_eff;
    assign core_clk_en = link.core_clk_en;

    core_clk_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .link(link)
    );
endmodule : pll_clock_ctrl

// *** clkctl_properties.sv ***
// checker: properties of the clock control register and its outputs
module clkctl_properties (
    // watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic powerdown,
    input wire logic irq_active,
    input wire logic osc_enable,
    input wire logic [2:0] core_clk_div_eff
);
    logic [7:0] sh;
    wire logic [2:0] code = sh[2:0];
    wire logic acc = psel && penable && paddr == 12'h000;
    wire logic rd = acc && !pwrite;
    // shadow of the writable fields, updated at the access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= 8'h03;
        end else begin
            sh <= acc && pwrite && pstrb[0] ? pwdata[7:0] : sh;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_osc_halts: assert property (powerdown && sh[7] |-> !osc_enable) else $error("osc");
    a_osc_runs: assert property (!(powerdown && sh[7]) |-> osc_enable) else $error("osc");
    a_field_read: assert property (rd |-> prdata[7] == sh[7] && prdata[3:0] == sh[3:0])
        else $error("read");
    a_rsvd_zero: assert property (rd |-> prdata[5] == 1'b0) else $error("reserved");
    a_fast_irq: assert property (irq_active && sh[3] |=> core_clk_div_eff == 3'h0)
        else $error("fast");
    a_irq_slow: assert property (irq_active && !sh[3] |=> core_clk_div_eff == $past(code))
        else $error("slow");
    a_div_resume: assert property (!irq_active |=> core_clk_div_eff == $past(code))
        else $error("div");
    a_unmapped_err: assert property (psel && penable && paddr != 12'h000 |-> pslverr)
        else $error("err");
    cover property (rd);
    cover property (irq_active && sh[3]);
    cover property (powerdown && sh[7]);
endmodule : clkctl_properties
bind pll_clock_ctrl clkctl_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pslverr, .powerdown, .irq_active, .osc_enable, .core_clk_div_eff);

// *** pll_core_clock_control_test.sv ***
// testbench: register, pin latch, lock, oscillator and divider scenarios
module pll_core_clock_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic ext_access_pin = 1, pll_tracking = 1, powerdown = 0, irq_active = 0, osc_enable;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [2:0] core_clk_div_eff;
    logic core_clk_en;
    int bad_count = 0, comparisons = 0;
    always #10 pclk = ~pclk;
    pll_clock_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .ext_access_pin, .pll_tracking, .powerdown,
        .irq_active, .osc_enable, .core_clk_en, .core_clk_div_eff);
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check("reg", q, 32'h0000_0053);
        apb(1'b1, 12'h000, 32'h0000_00df);
        ext_access_pin <= 1'b0;
        pll_tracking <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check("reg", q, 32'h0000_009f);
        apb(1'b0, 12'h004, 32'h0);
        check("unmapped", q, 32'h0000_0000);
        check("pslverr", err, 1'b1);
    endtask : t_regs
    task automatic t_osc;
        powerdown <= 1'b1;
        repeat (2) @(posedge pclk);
        check("osc", osc_enable, 1'b0);
        apb(1'b1, 12'h000, 32'h0000_0007);
        @(posedge pclk);
        check("osc", osc_enable, 1'b1);
        powerdown <= 1'b0;
        pll_tracking <= 1'b1;
        q = 0;
        // poll for lock after wake-up, as software must
        for (int i = 0; i < 9 && !q[6]; i++) apb(1'b0, 12'h000, 32'h0);
        check("lock", q[6], 1'b1);
    endtask : t_osc
    task automatic t_div;
        int pulses;
        for (logic [3:0] c = 0; c < 8; c++) begin
            apb(1'b1, 12'h000, {28'h000_0000, c});
            irq_active <= 1'b1;
            repeat (2) @(posedge pclk);
            check("div", core_clk_div_eff, c[2:0]);
            pulses = 0;
            repeat (128) begin
                @(negedge pclk);
                if (core_clk_en === 1'b1) pulses++;
            end
            check("core_clk_en", pulses, 32'd128 >> c);
            apb(1'b1, 12'h000, 32'h8 + c);
            repeat (2) @(posedge pclk);
            check("div", core_clk_div_eff, 3'h0);
            irq_active <= 1'b0;
            repeat (2) @(posedge pclk);
            check("div", core_clk_div_eff, c[2:0]);
        end
    endtask : t_div
    task automatic t_rerst;
        presetn <= 1'b0;
        @(posedge pclk);
        check("div_rst", core_clk_div_eff, 3'h3);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        check("reg_rst", q, 32'h0000_0043);
    endtask : t_rerst
    task automatic print_verdict;
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_regs;
        t_osc;
        t_div;
        t_rerst;
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        print_verdict;
    end
endmodule : pll_core_clock_control_test
